// file: tsc_capture.sv
// time snapshot capture: event latching of time-of-day, cable master time and status regs
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps

module tsc_capture
    import tsc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // register bus
    input wire tsc_bus_req_s bus_req,
    output logic [31:0] rd_data,
    // time sources on the core clock
    input wire tsc_time_s tod,
    input wire logic [31:0] tick_high,
    // event pins, asynchronous to the core clock
    input wire logic gps_pps_pin,
    input wire logic irig_pps_pin,
    input wire logic cable_time_rx_pin,
    // cable side
    input wire logic master_mode,
    input wire logic [7:0] cable_err_event,
    input wire logic [31:0] out_cable_hw_status,
    input wire logic [23:0] in_cable_hw_status,
    output logic [31:0] cable_tx_seconds,
    output logic cable_tx_strobe,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        // pin synchronisers and filtered levels
        logic [2:0][2:0] sync;
        logic [2:0] level;

        // previous seconds sample for boundary detection
        logic sec_valid;
        logic [31:0] prev_sec;

        // snapshot pairs, one per event source
        tsc_snap_s gps;
        tsc_snap_s cab;
        tsc_snap_s irig;

        // last seconds value sent as master
        logic [31:0] master_sec;

        // sticky errors, event status and mask
        logic [7:0] cable_err;
        logic [4:0] ev_status;
        logic [4:0] ev_mask;

        // registered outputs
        logic [31:0] rd_data;
        logic irq;
        logic [31:0] tx_sec;
        logic tx_stb;
    } tsc_state_s;

    localparam tsc_state_s TSC_STATE_RST = '{
        sync: '0,
        level: '0,
        sec_valid: 1'b0,
        prev_sec: TSC_SNAP_RST,
        gps: '{
            seconds: TSC_SNAP_RST,
            snap: TSC_SNAP_RST
        },
        cab: '{
            seconds: TSC_SNAP_RST,
            snap: TSC_SNAP_RST
        },
        irig: '{
            seconds: TSC_SNAP_RST,
            snap: TSC_SNAP_RST
        },
        master_sec: TSC_SNAP_RST,
        cable_err: TSC_ERR_RST,
        ev_status: '0,
        ev_mask: TSC_EV_MASK_RST,
        rd_data: TSC_SNAP_RST,
        irq: 1'b0,
        tx_sec: TSC_SNAP_RST,
        tx_stb: 1'b0
    };

    tsc_state_s state_reg;
    tsc_state_s state_next;

    // per-source pins and events, this cycle's snapshot word and write decodes
    logic [2:0] pins;
    logic [2:0] src_event;
    tsc_snap_s now_snap;
    logic sec_boundary;
    logic [4:0] ev_set;
    logic err_any;
    logic wr_err_clr;
    logic wr_ev_status;
    logic wr_ev_mask;

    assign pins[TSC_SRC_GPS] = gps_pps_pin;
    assign pins[TSC_SRC_IRIG] = irig_pps_pin;
    assign pins[TSC_SRC_CABLE] = cable_time_rx_pin;

    // ------------------------------------------------------------------
    // event detection per source
    // ------------------------------------------------------------------
    // a rising level counts only once stages two and three agree, so a
    // metastable first stage never fires a capture by itself
    genvar gi;
    generate
        for (gi = 0; gi < TSC_SRC_N; gi++)
        begin : g_src
            assign src_event[gi] = state_reg.sync[gi][1] & state_reg.sync[gi][2]
                & ~state_reg.level[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // snapshot word
    // ------------------------------------------------------------------
    // one snapshot word built from a single sample of the clock
    assign now_snap.seconds = tod.seconds;
    assign now_snap.snap = {tod.seconds[TSC_SEC_LOW_W-1:0],
        tod.nanoseconds[TSC_NS_W-1:0]};

    // ------------------------------------------------------------------
    // seconds boundary, errors and write decode
    // ------------------------------------------------------------------
    // a seconds step seen after the first sample marks the boundary; the first
    // sample after reset has nothing to compare with and never counts
    assign sec_boundary = state_reg.sec_valid && (tod.seconds != state_reg.prev_sec);

    assign err_any = |cable_err_event;

    // the clear location ignores its data: any write there clears
    assign wr_err_clr = bus_req.wr && (bus_req.addr == TSC_ERR_CLR_OFF);
    assign wr_ev_status = bus_req.wr && (bus_req.addr == TSC_EV_STATUS_OFF);
    assign wr_ev_mask = bus_req.wr && (bus_req.addr == TSC_EV_MASK_OFF);

    // ------------------------------------------------------------------
    // event set vector
    // ------------------------------------------------------------------
    always_comb
    begin
        ev_set = '0;
        ev_set[TSC_EV_GPS] = src_event[TSC_SRC_GPS];
        ev_set[TSC_EV_IRIG] = src_event[TSC_SRC_IRIG];
        ev_set[TSC_EV_CABLE_RX] = src_event[TSC_SRC_CABLE];
        ev_set[TSC_EV_MASTER_TX] = sec_boundary & master_mode;
        ev_set[TSC_EV_CABLE_ERR] = err_any;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;

        // --------------------------------------------------------------
        // synchronisers and filtered levels
        // --------------------------------------------------------------
        // shift each pin through three stages; the level follows only once
        // stages two and three agree
        for (int i = 0; i < TSC_SRC_N; i++)
        begin
            state_next.sync[i] = {state_reg.sync[i][1:0], pins[i]};
            if (state_reg.sync[i][1] == state_reg.sync[i][2])
            begin
                state_next.level[i] = state_reg.sync[i][2];
            end
        end

        // --------------------------------------------------------------
        // snapshots change only on their own source; software cannot write them
        // --------------------------------------------------------------
        if (src_event[TSC_SRC_GPS])
        begin
            state_next.gps = now_snap;
        end
        if (src_event[TSC_SRC_CABLE])
        begin
            state_next.cab = now_snap;
        end
        if (src_event[TSC_SRC_IRIG])
        begin
            state_next.irig = now_snap;
        end

        // --------------------------------------------------------------
        // master transmission at each whole-second step
        // --------------------------------------------------------------
        state_next.sec_valid = 1'b1;
        state_next.prev_sec = tod.seconds;
        // the strobe stands one cycle for each load of the sent value
        state_next.tx_stb = 1'b0;
        if (sec_boundary && master_mode)
        begin
            state_next.tx_sec = tod.seconds;
            state_next.tx_stb = 1'b1;
            state_next.master_sec = tod.seconds;
        end

        // --------------------------------------------------------------
        // cable errors: clear first so that a same-cycle error still lands
        // --------------------------------------------------------------
        if (wr_err_clr)
        begin
            state_next.cable_err = TSC_ERR_RST;
        end
        state_next.cable_err = state_next.cable_err | cable_err_event;

        // --------------------------------------------------------------
        // event status: write one to clear, new events win
        // --------------------------------------------------------------
        if (wr_ev_status)
        begin
            state_next.ev_status = state_reg.ev_status & ~bus_req.wdata[TSC_EV_W-1:0];
        end
        state_next.ev_status = state_next.ev_status | ev_set;

        if (wr_ev_mask)
        begin
            state_next.ev_mask = bus_req.wdata[TSC_EV_W-1:0];
        end

        // taken from the next status and mask, so irq follows a new event or a
        // clear at the same edge instead of one cycle late
        state_next.irq = |(state_next.ev_status & state_next.ev_mask);

        // --------------------------------------------------------------
        // read data valid only in the cycle after the strobe
        // --------------------------------------------------------------
        state_next.rd_data = '0;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                TSC_GPS_NS_OFF:
                begin
                    state_next.rd_data = state_reg.gps.snap;
                end
                TSC_GPS_SEC_OFF:
                begin
                    state_next.rd_data = state_reg.gps.seconds;
                end
                TSC_CAB_NS_OFF:
                begin
                    state_next.rd_data = state_reg.cab.snap;
                end
                TSC_CAB_SEC_OFF:
                begin
                    state_next.rd_data = state_reg.cab.seconds;
                end
                TSC_MASTER_SEC_OFF:
                begin
                    state_next.rd_data = state_reg.master_sec;
                end
                TSC_IRIG_NS_OFF:
                begin
                    state_next.rd_data = state_reg.irig.snap;
                end
                TSC_IRIG_SEC_OFF:
                begin
                    state_next.rd_data = state_reg.irig.seconds;
                end
                TSC_OUT_CABLE_OFF:
                begin
                    state_next.rd_data = out_cable_hw_status;
                end
                TSC_IN_CABLE_OFF:
                begin
                    state_next.rd_data = {in_cable_hw_status, state_reg.cable_err};
                end
                TSC_EV_STATUS_OFF:
                begin
                    state_next.rd_data = {27'h0000000, state_reg.ev_status};
                end
                TSC_EV_MASK_OFF:
                begin
                    state_next.rd_data = {27'h0000000, state_reg.ev_mask};
                end
                TSC_TICK_HI_OFF_A, TSC_TICK_HI_OFF_B:
                begin
                    state_next.rd_data = tick_high;
                end
                TSC_ERR_CLR_OFF:
                begin
                    // write-only location
                    state_next.rd_data = '0;
                end
                default:
                begin
                    // unmapped addresses read zero
                    state_next.rd_data = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // the reset branch loads constants only
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= TSC_STATE_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // every output is a state flop, never a gate after one
    assign rd_data = state_reg.rd_data;
    assign cable_tx_seconds = state_reg.tx_sec;
    assign cable_tx_strobe = state_reg.tx_stb;
    assign irq = state_reg.irq;

endmodule

// file: tsc_pkg.sv
// constants, register map and carrier types of the time snapshot capture block
package tsc_pkg;

    // ------------------------------------------------------------------
    // bus and field widths
    // ------------------------------------------------------------------
    localparam int TSC_ADDR_W = 17;
    localparam int TSC_DATA_W = 32;
    localparam int TSC_NS_W = 30;
    localparam int TSC_SEC_LOW_W = 2;
    localparam int TSC_ERR_W = 8;
    localparam int TSC_IN_HW_W = 24;
    localparam int TSC_SYNC_W = 3;
    localparam int TSC_SRC_N = 3;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [16:0] TSC_GPS_NS_OFF = 17'h00200;
    localparam logic [16:0] TSC_GPS_SEC_OFF = 17'h00204;
    localparam logic [16:0] TSC_CAB_NS_OFF = 17'h00210;
    localparam logic [16:0] TSC_CAB_SEC_OFF = 17'h00214;
    localparam logic [16:0] TSC_MASTER_SEC_OFF = 17'h00220;
    localparam logic [16:0] TSC_IRIG_NS_OFF = 17'h00230;
    localparam logic [16:0] TSC_IRIG_SEC_OFF = 17'h00234;
    localparam logic [16:0] TSC_ERR_CLR_OFF = 17'h00400;
    localparam logic [16:0] TSC_OUT_CABLE_OFF = 17'h00410;
    localparam logic [16:0] TSC_IN_CABLE_OFF = 17'h00420;
    localparam logic [16:0] TSC_EV_STATUS_OFF = 17'h00500;
    localparam logic [16:0] TSC_EV_MASK_OFF = 17'h00504;
    localparam logic [16:0] TSC_TICK_HI_OFF_A = 17'h01000;
    localparam logic [16:0] TSC_TICK_HI_OFF_B = 17'h10000;

    // ------------------------------------------------------------------
    // event bit positions in status and mask
    // ------------------------------------------------------------------
    localparam int TSC_EV_GPS = 0;
    localparam int TSC_EV_IRIG = 1;
    localparam int TSC_EV_CABLE_RX = 2;
    localparam int TSC_EV_MASTER_TX = 3;
    localparam int TSC_EV_CABLE_ERR = 4;
    localparam int TSC_EV_W = 5;

    // source index in the pin synchroniser vector
    localparam int TSC_SRC_GPS = 0;
    localparam int TSC_SRC_IRIG = 1;
    localparam int TSC_SRC_CABLE = 2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] TSC_SNAP_RST = 32'h0000_0000;
    localparam logic [4:0] TSC_EV_MASK_RST = 5'h00;
    localparam logic [7:0] TSC_ERR_RST = 8'h00;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [16:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tsc_bus_req_s;

    typedef struct packed {
        logic [31:0] seconds;
        logic [31:0] nanoseconds;
    } tsc_time_s;

    typedef struct packed {
        logic [31:0] seconds;
        logic [31:0] snap;
    } tsc_snap_s;

endpackage

// file: tsc_capture_properties.sv
// port-level assertions and covers for the time snapshot capture block
`timescale 1ns/10ps
module tsc_capture_properties
    import tsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire tsc_bus_req_s bus_req,
    input wire logic [31:0] rd_data,
    input wire tsc_time_s tod,
    input wire logic [31:0] tick_high,
    input wire logic master_mode,
    input wire logic [7:0] cable_err_event,
    input wire logic [31:0] out_cable_hw_status,
    input wire logic [23:0] in_cable_hw_status,
    input wire logic [31:0] cable_tx_seconds,
    input wire logic cable_tx_strobe,
    input wire logic irq
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // address zero is never decoded, so it stands for no access
    logic [16:0] ra;
    logic [16:0] wa;
    logic [1:0] up_reg;
    logic [1:0] up_next;
    assign ra = bus_req.rd ? bus_req.addr : 17'h0;
    assign wa = bus_req.wr ? bus_req.addr : 17'h0;
    // the first seconds sample after reset has nothing to compare with
    assign up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            up_reg <= 2'h0;
        else
            up_reg <= up_next;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    AST_RD_IDLE: assert property (!bus_req.rd |=> rd_data == 32'h0)
        else $error("read data not zero outside a read answer");
    AST_TICK_A: assert property (ra == TSC_TICK_HI_OFF_A |=> rd_data == $past(tick_high))
        else $error("tick upper word wrong at first offset");
    AST_TICK_B: assert property (ra == TSC_TICK_HI_OFF_B |=> rd_data == $past(tick_high))
        else $error("tick upper word wrong at second offset");
    AST_OUT_CABLE: assert property (ra == TSC_OUT_CABLE_OFF |=> rd_data == $past(out_cable_hw_status))
        else $error("output cable state read wrong");
    AST_IN_CABLE: assert property (ra == TSC_IN_CABLE_OFF |=> rd_data[31:8] == $past(in_cable_hw_status))
        else $error("input cable state read wrong");
    AST_TX_LOAD: assert property (up_reg == 2'h3 && master_mode && $changed(tod.seconds)
        |=> cable_tx_strobe && cable_tx_seconds == $past(tod.seconds))
        else $error("seconds boundary not sent");
    AST_TX_CAUSE: assert property (cable_tx_strobe |-> $past(master_mode)
        && $past(tod.seconds) != $past(tod.seconds, 2))
        else $error("seconds sent without a boundary");
    AST_ERR_CLR: assert property (wa == TSC_ERR_CLR_OFF && cable_err_event == 8'h00
        ##1 ra == TSC_IN_CABLE_OFF && cable_err_event == 8'h00 |=> rd_data[7:0] == 8'h00)
        else $error("cable errors not cleared");
    AST_IRQ_MASK: assert property (wa == TSC_EV_MASK_OFF && bus_req.wdata[4:0] == 5'h00
        ##1 wa != TSC_EV_MASK_OFF |=> !irq)
        else $error("interrupt high with all events masked");
    COV_TX: cover property (cable_tx_strobe);
    COV_IRQ: cover property (irq ##1 !irq);
    COV_ERR: cover property (ra == TSC_IN_CABLE_OFF ##1 rd_data[7:0] != 8'h00);
endmodule

bind tsc_capture tsc_capture_properties i_props (.core_clk, .arst_n, .bus_req, .rd_data, .tod,
    .tick_high, .master_mode, .cable_err_event, .out_cable_hw_status, .in_cable_hw_status,
    .cable_tx_seconds, .cable_tx_strobe, .irq);

// file: tsc_far_side.sv
// far-side model: gps and irig pulse sources and the cable time receiver
`timescale 1ns/10ps
module tsc_far_side
    import tsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic [2:0] fire,
    input wire logic slow,
    output logic gps_pps_pin,
    output logic irig_pps_pin,
    output logic cable_time_rx_pin
);
    // ------------------------------------------------------------------
    // pulse timers
    // ------------------------------------------------------------------
    // slow mode holds the pin far past detection: it must still count once
    logic [3:0] left [TSC_SRC_N] = '{default: 4'h0};
    always @(posedge core_clk)
    begin
        for (int i = 0; i < TSC_SRC_N; i++)
        begin
            if (fire[i])
                left[i] <= slow ? 4'hc : 4'h3;
            else if (left[i] != 4'h0)
                left[i] <= left[i] - 4'h1;
        end
    end
    assign gps_pps_pin = left[TSC_SRC_GPS] != 4'h0;
    assign irig_pps_pin = left[TSC_SRC_IRIG] != 4'h0;
    assign cable_time_rx_pin = left[TSC_SRC_CABLE] != 4'h0;
endmodule

// file: tsc_capture_tb.sv
// self-checking bench for the time snapshot capture block
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tsc_capture_tb
    import tsc_pkg::*;
();
    logic core_clk = 1'b0, arst_n = 1'b0, master_mode = 1'b0, run = 1'b1, slow = 1'b0;
    tsc_bus_req_s bus_req = '0;
    tsc_time_s tod;
    logic [31:0] rd_data, tx_sec, v, t0, sec, snap;
    logic [31:0] tick_high = 32'h0, out_hw = 32'h0, ns_cnt = 32'h0, sec_base = 32'h0;
    logic [23:0] in_hw = 24'h0;
    logic [7:0] err_ev = 8'h0;
    logic [2:0] fire = 3'h0;
    logic gps_pin, irig_pin, cab_pin, irq, tx_strobe;
    int errors = 0, samples_checked = 0, cycles = 0;
    logic [16:0] ro_offs [8] = '{TSC_GPS_NS_OFF, TSC_GPS_SEC_OFF, TSC_CAB_NS_OFF,
        TSC_CAB_SEC_OFF, TSC_IRIG_NS_OFF, TSC_IRIG_SEC_OFF, TSC_MASTER_SEC_OFF, 17'h00300};
    assign tod = '{seconds: sec_base + ns_cnt, nanoseconds: ns_cnt};
    tsc_capture i_dut (.core_clk, .arst_n, .bus_req, .rd_data, .tod, .tick_high,
        .gps_pps_pin(gps_pin), .irig_pps_pin(irig_pin), .cable_time_rx_pin(cab_pin),
        .master_mode, .cable_err_event(err_ev), .out_cable_hw_status(out_hw),
        .in_cable_hw_status(in_hw), .cable_tx_seconds(tx_sec), .cable_tx_strobe(tx_strobe), .irq);
    tsc_far_side i_far (.core_clk, .fire, .slow, .gps_pps_pin(gps_pin),
        .irig_pps_pin(irig_pin), .cable_time_rx_pin(cab_pin));
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        if (run)
            ns_cnt <= ns_cnt + 32'h1;
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            end_of_test();
        end
    end
    function automatic logic [31:0] snap_word(input logic [31:0] s, input logic [31:0] n);
        return {s[1:0], n[29:0]};
    endfunction
    task automatic end_of_test();
        $display("checked %0d values, %0d mismatches", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [16:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask
    task automatic nap(input int n);
        @(posedge core_clk);
        bus_req <= '0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [16:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1 d = rd_data;
    endtask
    task automatic chk_rd(input logic [16:0] a, input logic [31:0] e);
        rd(a, v);
        `CHK(v, e)
    endtask
    // pins rise one edge after fire, so capture lands near t0 plus four
    task automatic pulse(input int s);
        logic [16:0] nso;
        nso = (s == TSC_SRC_GPS) ? TSC_GPS_NS_OFF : (s == TSC_SRC_IRIG) ? TSC_IRIG_NS_OFF
            : TSC_CAB_NS_OFF;
        @(posedge core_clk);
        fire[s] <= 1'b1;
        #1 t0 = ns_cnt;
        @(posedge core_clk);
        fire[s] <= 1'b0;
        nap(12);
        rd(nso, snap);
        rd(nso + 17'h4, sec);
        `CHK(snap[29:0] - t0[29:0] inside {[30'd3:30'd5]}, 1'b1)
        `CHK(sec, sec_base + t0 + 32'h4)
        `CHK(snap, snap_word(sec_base + t0 + 32'h4, t0 + 32'h4))
        rd(TSC_EV_STATUS_OFF, v);
        `CHK(v[s], 1'b1)
        `CHK(irq, 1'b1)
        wr(TSC_EV_STATUS_OFF, 32'h1 << s);
        wr(nso, $urandom);
        nap(2);
        `CHK(irq, 1'b0)
        chk_rd(nso, snap);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(2));
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        tick_high <= $urandom;
        out_hw <= $urandom;
        in_hw <= $urandom;
        foreach (ro_offs[i]) chk_rd(ro_offs[i], 32'h0);
        $display("test reset values done");
        wr(TSC_EV_MASK_OFF, 32'h7);
        nap(0);
        for (int r = 0; r < 3; r++)
        begin
            for (int s = 0; s < TSC_SRC_N; s++)
            begin
                @(posedge core_clk);
                sec_base <= $urandom;
                master_mode <= $urandom;
                slow <= r[0];
                pulse(s);
            end
        end
        $display("test pulse captures done");
        @(posedge core_clk);
        run <= 1'b0;
        master_mode <= 1'b1;
        sec_base <= $urandom;
        nap(3);
        t0 = sec_base + ns_cnt;
        chk_rd(TSC_MASTER_SEC_OFF, t0);
        @(posedge core_clk);
        master_mode <= 1'b0;
        sec_base <= sec_base + 32'h7;
        nap(3);
        chk_rd(TSC_MASTER_SEC_OFF, t0);
        `CHK(tx_sec, t0)
        run <= 1'b1;
        $display("test master time done");
        v = $urandom;
        @(posedge core_clk);
        err_ev <= v[7:0] | 8'h01;
        @(posedge core_clk);
        err_ev <= 8'h00;
        chk_rd(TSC_IN_CABLE_OFF, {in_hw, v[7:0] | 8'h01});
        wr(TSC_ERR_CLR_OFF, $urandom);
        chk_rd(TSC_IN_CABLE_OFF, {in_hw, 8'h00});
        chk_rd(TSC_OUT_CABLE_OFF, out_hw);
        chk_rd(TSC_TICK_HI_OFF_A, tick_high);
        chk_rd(TSC_TICK_HI_OFF_B, tick_high);
        wr(TSC_EV_MASK_OFF, 32'h1 << TSC_EV_CABLE_ERR);
        nap(2);
        `CHK(irq, 1'b1)
        wr(TSC_EV_MASK_OFF, 32'h0);
        nap(2);
        `CHK(irq, 1'b0)
        $display("test status registers done");
        end_of_test();
    end
endmodule
